// ### common/tcr_pkg.sv
/*
 * Package for the timebase and reference-A configuration bank: register
 * indices, reset values, writable masks, field carriers and bus carriers.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
package tcr_pkg;

   // Register count and address widths.
   localparam int TCR_NREG    = 20;
   localparam int TCR_ADR_W   = 14;
   localparam int TCR_IDX_W   = 12;

   // Register indices; the byte address is four times the index.
   localparam logic [11:0] TCR_IDX [TCR_NREG] = '{
      12'h200, 12'h201, 12'h202, 12'h203, 12'h204, 12'h205, 12'h206, 12'h207,
      12'h300, 12'h301, 12'h302, 12'h303, 12'h304, 12'h305, 12'h306, 12'h307,
      12'h308, 12'h309, 12'h30a, 12'h30b};

   // Reset values in the same order.
   localparam logic [7:0] TCR_RST [TCR_NREG] = '{
      8'h08, 8'h09, 8'h0e, 8'h67, 8'h13, 8'h32, 8'h00, 8'h00,
      8'h00, 8'hcf, 8'h00, 8'h00, 8'hc9, 8'he9, 8'h10, 8'h03,
      8'h00, 8'h14, 8'h00, 8'h00};

   // Writable bits; reserved bits stay zero and read as zero.
   localparam logic [7:0] TCR_MASK [TCR_NREG] = '{
      8'hff, 8'h0f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h0f,
      8'h0b, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'h0f};

   // Positions of each field's lowest byte in the arrays above.
   localparam int TCR_POS_FB_DIV  = 0;
   localparam int TCR_POS_FB_CFG  = 1;
   localparam int TCR_POS_SPER    = 2;
   localparam int TCR_POS_STAB    = 5;
   localparam int TCR_POS_RTYPE   = 8;
   localparam int TCR_POS_RDIV    = 9;
   localparam int TCR_POS_RPER    = 12;
   localparam int TCR_POS_RTOL    = 17;

   // Bit positions inside the feedback config and input type bytes.
   localparam int TCR_BIT_DOUBLER = 0;
   localparam int TCR_BIT_PRESC   = 1;
   localparam int TCR_BIT_XTAL    = 3;
   localparam int TCR_BIT_DIV2    = 3;

   // Read-only status register of the bank itself.
   localparam logic [11:0] TCR_IDX_STATUS = 12'h3f0;
   localparam int TCR_BIT_TOL_OK   = 0;
   localparam int TCR_BIT_RPER_OK  = 1;
   localparam int TCR_BIT_RDIV_OK  = 2;

   // Inner tolerance limits as reciprocal ppm: 10 percent and 2 ppm.
   localparam logic [19:0] TCR_TOL_RECIP_MIN = 20'h0000a;
   localparam logic [19:0] TCR_TOL_RECIP_MAX = 20'h7a120;

   // Classic Wishbone request from the master.
   typedef struct packed {
      logic                 cyc;
      logic                 stb;
      logic                 we;
      logic [TCR_ADR_W-1:0] adr;
      logic [3:0]           sel;
      logic [31:0]          dat;
   } tcr_wb_req_type;

   // Timebase PLL settings as seen by the timebase logic.
   typedef struct packed {
      logic [7:0]  fb_div;
      logic        crystal_oscillator_enable;
      logic [1:0]  timebase_input_prescaler;
      logic        timebase_doubler;
      logic [20:0] period_fs;
      logic [19:0] stability_ms;
   } tcr_sys_cfg_type;

   // Reference input A settings as seen by the monitor and divider.
   typedef struct packed {
      logic [1:0]  logic_type;
      logic        div2_en;
      logic [19:0] r_div;
      logic [39:0] period_fs;
      logic [19:0] lock_tol;
      logic [19:0] lock_tol_eff;
   } tcr_ref_a_cfg_type;

endpackage

// ### logic/tcr_cfg_byte.sv
/*
 * One byte-wide configuration register with a reset value and a mask of
 * writable bits. Assumes the write strobe is already decoded and qualified.
 */
`timescale 1ns/1ps
`default_nettype none

module tcr_cfg_byte #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hff
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdat_i,
   output logic      [7:0] q_o
);

   // Reserved bits are forced to zero on reset and on every write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= RST_VAL & WR_MASK;
      end else if (wr_i) begin
         q_o <= wdat_i & WR_MASK;
      end
   end

endmodule

`default_nettype wire

// ### logic/tcr_regs.sv
/*
 * Configuration bank for the system timebase PLL and reference input A,
 * reached as a classic Wishbone slave, one byte register per 32-bit word.
 * Assumes one clock and a synchronous active-high reset; consumers of the
 * decoded fields live outside this module.
 */
// Operation
// - Reference-A nominal period is femtoseconds, default near 51.44 ns.
// - Reference-A period is 40 bits over five bytes, top byte bits 39:32.
// - Inner tolerance is reciprocal ppm, used for lock entry, 10 percent to 2 ppm.
// - Inner tolerance is 20 bits; top four bits low in third byte.
// - Timebase stability is 20 bits of milliseconds, top nibble third byte.
// - One byte holds reference-A logic type and divide-by-2 enable.
`timescale 1ns/1ps
`default_nettype none

module tcr_regs (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire tcr_pkg::tcr_wb_req_type    wb_i,
   output logic                            ack_o,
   output logic [31:0]                     dat_o,
   output tcr_pkg::tcr_sys_cfg_type        sys_cfg_o,
   output tcr_pkg::tcr_ref_a_cfg_type      ref_a_cfg_o,
   output logic                            tol_in_range_o
);
   import tcr_pkg::*;

   logic [TCR_IDX_W-1:0] idx;
   logic [TCR_NREG-1:0]  hit;
   logic                 req;
   logic                 wr_en;
   logic [7:0]           rb [TCR_NREG];
   logic [7:0]           next_rd;
   logic [7:0]           status;
   logic                 tol_ok;
   logic [19:0]          next_tol_eff;

   // Word index from the byte address; the low two bits are ignored.
   assign idx = wb_i.adr[TCR_ADR_W-1:2];

   // A new request is taken only while no answer is standing.
   assign req   = wb_i.cyc & wb_i.stb & ~ack_o;
   assign wr_en = req & wb_i.we & wb_i.sel[0];

   // Address decode against the index table.
   always_comb begin
      for (int i = 0; i < TCR_NREG; i++) begin
         hit[i] = (idx == TCR_IDX[i]);
      end
   end

   // byte order
   // Each register is one instance; index order follows field byte order.
   genvar g;
   generate
      for (g = 0; g < TCR_NREG; g++) begin : g_reg
         tcr_cfg_byte #(
            .RST_VAL (TCR_RST[g]),
            .WR_MASK (TCR_MASK[g])
         ) u_byte (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .wr_i   (wr_en & hit[g]),
            .wdat_i (wb_i.dat[7:0]),
            .q_o    (rb[g])
         );
      end
   endgenerate

   // Timebase fields.
   // stability width
   always_comb begin
      sys_cfg_o.fb_div                    = rb[TCR_POS_FB_DIV];
      sys_cfg_o.crystal_oscillator_enable = rb[TCR_POS_FB_CFG][TCR_BIT_XTAL];
      sys_cfg_o.timebase_input_prescaler  = rb[TCR_POS_FB_CFG][TCR_BIT_PRESC +: 2];
      sys_cfg_o.timebase_doubler          = rb[TCR_POS_FB_CFG][TCR_BIT_DOUBLER];
      sys_cfg_o.period_fs    = {rb[TCR_POS_SPER+2][4:0], rb[TCR_POS_SPER+1],
                                rb[TCR_POS_SPER]};
      sys_cfg_o.stability_ms = {rb[TCR_POS_STAB+2][3:0], rb[TCR_POS_STAB+1],
                                rb[TCR_POS_STAB]};
   end

   // Reference A fields.
   // type and divide
   always_comb begin
      ref_a_cfg_o.logic_type = rb[TCR_POS_RTYPE][1:0];
      ref_a_cfg_o.div2_en    = rb[TCR_POS_RTYPE][TCR_BIT_DIV2];
      ref_a_cfg_o.r_div      = {rb[TCR_POS_RDIV+2][3:0], rb[TCR_POS_RDIV+1],
                                rb[TCR_POS_RDIV]};
      ref_a_cfg_o.period_fs  = {rb[TCR_POS_RPER+4], rb[TCR_POS_RPER+3],
                                rb[TCR_POS_RPER+2], rb[TCR_POS_RPER+1],
                                rb[TCR_POS_RPER]};
      ref_a_cfg_o.lock_tol   = {rb[TCR_POS_RTOL+2][3:0], rb[TCR_POS_RTOL+1],
                                rb[TCR_POS_RTOL]};
      ref_a_cfg_o.lock_tol_eff = next_tol_eff;
   end

   // tolerance clamp
   // Out-of-range tolerances are clamped on lock_tol_eff but passed on raw on lock_tol, so
   // lock_tol_eff never carries a window wider than 10 percent or below 2 ppm.
   // The clamped value goes through its own variable so that the output
   // struct keeps a single driving process.
   always_comb begin
      tol_ok = (ref_a_cfg_o.lock_tol >= TCR_TOL_RECIP_MIN)
             & (ref_a_cfg_o.lock_tol <= TCR_TOL_RECIP_MAX);
      if (ref_a_cfg_o.lock_tol < TCR_TOL_RECIP_MIN) begin
         next_tol_eff = TCR_TOL_RECIP_MIN;
      end else if (ref_a_cfg_o.lock_tol > TCR_TOL_RECIP_MAX) begin
         next_tol_eff = TCR_TOL_RECIP_MAX;
      end else begin
         next_tol_eff = ref_a_cfg_o.lock_tol;
      end
   end

   assign tol_in_range_o = tol_ok;

   // Status of the bank itself, read-only.
   always_comb begin
      status                  = 8'h00;
      status[TCR_BIT_TOL_OK]  = tol_ok;
      status[TCR_BIT_RPER_OK] = |ref_a_cfg_o.period_fs;
      status[TCR_BIT_RDIV_OK] = |ref_a_cfg_o.r_div;
   end

   // Read mux; unmapped indices read as zero.
   always_comb begin
      next_rd = 8'h00;
      for (int i = 0; i < TCR_NREG; i++) begin
         if (hit[i]) begin
            next_rd = rb[i];
         end
      end
      if (idx == TCR_IDX_STATUS) begin
         next_rd = status;
      end
   end

   // Registered acknowledge: one cycle after the request, one cycle long.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // Read data is captured with the acknowledge and held until the next one.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req) begin
         dat_o <= {24'h00_0000, next_rd};
      end
   end

endmodule

`default_nettype wire

// ### sim/tcr_regs_props.sv
/* Checker for the timebase and reference-A configuration bank.
   Assumes it sees only the ports of tcr_regs, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tcr_regs_props (
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire tcr_pkg::tcr_wb_req_type    wb_i,
   input wire logic                       ack_o,
   input wire logic [31:0]                dat_o,
   input wire tcr_pkg::tcr_sys_cfg_type   sys_cfg_o,
   input wire tcr_pkg::tcr_ref_a_cfg_type ref_a_cfg_o,
   input wire logic                       tol_in_range_o
);
   import tcr_pkg::*;
   // A write is taken only while ack is low; sel[0] qualifies it.
   wire logic        wr = wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0] && !ack_o;
   wire logic [11:0] ix = wb_i.adr[13:2];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   per_low_a: assert property (
      wr && ix == 12'h304 |=> ref_a_cfg_o.period_fs[7:0] == $past(wb_i.dat[7:0]))
      else $error("period low byte wrong");
   per_top_a: assert property (
      wr && ix == 12'h308 |=> ref_a_cfg_o.period_fs[39:32] == $past(wb_i.dat[7:0]))
      else $error("period top byte wrong");
   tol_range_a: assert property (
      tol_in_range_o == (ref_a_cfg_o.lock_tol >= 20'd10 && ref_a_cfg_o.lock_tol <= 20'd500000))
      else $error("tolerance range flag wrong");
   tol_clamp_a: assert property (
      ref_a_cfg_o.lock_tol < 20'd10 |-> ref_a_cfg_o.lock_tol_eff == 20'd10)
      else $error("tolerance low clamp wrong");
   tol_top_a: assert property (
      wr && ix == 12'h30b |=> ref_a_cfg_o.lock_tol[19:16] == $past(wb_i.dat[3:0]))
      else $error("tolerance top nibble wrong");
   stab_top_a: assert property (
      wr && ix == 12'h207 |=> sys_cfg_o.stability_ms[19:16] == $past(wb_i.dat[3:0]))
      else $error("stability top nibble wrong");
   type_byte_a: assert property (
      wr && ix == 12'h300 |=> {ref_a_cfg_o.div2_en, ref_a_cfg_o.logic_type}
         == {$past(wb_i.dat[3]), $past(wb_i.dat[1:0])}) else $error("type byte wrong");
   tol_lsb_a: assert property (
      wr && ix == 12'h309 |=> ref_a_cfg_o.lock_tol[7:0] == $past(wb_i.dat[7:0]))
      else $error("tolerance low byte wrong");
   ack_pulse_a: assert property (
      wb_i.cyc && wb_i.stb && !ack_o |=> ack_o ##1 !ack_o) else $error("ack not one pulse");
endmodule
bind tcr_regs tcr_regs_props tcr_regs_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
   .ack_o(ack_o), .dat_o(dat_o), .sys_cfg_o(sys_cfg_o), .ref_a_cfg_o(ref_a_cfg_o),
   .tol_in_range_o(tol_in_range_o));
`default_nettype wire

// ### sim/tcr_regs_tb.sv
/* Self-checking bench for the configuration bank over classic Wishbone.
   Assumes the package in common/ and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tcr_regs_tb;
   import tcr_pkg::*;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   tcr_wb_req_type    wb_i = '0;
   logic              ack_o;
   logic [31:0]       dat_o;
   tcr_sys_cfg_type   sys_cfg_o;
   tcr_ref_a_cfg_type ref_a_cfg_o;
   logic              tol_in_range_o;
   int                miscompares = 0;
   int                checks_done = 0;
   logic [7:0]        sh [TCR_NREG];
   logic [31:0]       rd;
   logic [19:0]       tv [4] = '{20'd9, 20'd10, 20'd500000, 20'd500001};
   tcr_regs tcr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .ack_o(ack_o),
      .dat_o(dat_o), .sys_cfg_o(sys_cfg_o), .ref_a_cfg_o(ref_a_cfg_o),
      .tol_in_range_o(tol_in_range_o));
   // Clock at 125 MHz.
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic conclude;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled, then drops a cycle.
   task automatic bus(input logic we, input logic [11:0] ix, input logic [7:0] d,
                      input logic [3:0] sel);
      int n;
      n = 0;
      wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {ix, 2'b00}, sel: sel, dat: {24'h0, d}};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rd = dat_o;
      wb_i.cyc <= 1'b0;
      wb_i.stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // Reads every register back against the shadow copy.
   task automatic rd_all;
      for (int i = 0; i < TCR_NREG; i++) begin
         bus(1'b0, TCR_IDX[i], 8'h00, 4'hf);
         cmp(rd, {24'h0, sh[i]});
      end
   endtask
   // Decoded fields are rebuilt from the shadow bytes, lowest address lowest byte.
   task automatic chk_fields;
      logic [19:0] t;
      t = {sh[19][3:0], sh[18], sh[17]};
      cmp(ref_a_cfg_o.period_fs, {sh[16], sh[15], sh[14], sh[13], sh[12]});
      cmp(ref_a_cfg_o.lock_tol, t);
      cmp(sys_cfg_o.stability_ms, {sh[7][3:0], sh[6], sh[5]});
      cmp({ref_a_cfg_o.div2_en, ref_a_cfg_o.logic_type}, {sh[8][3], sh[8][1:0]});
      cmp(ref_a_cfg_o.r_div, {sh[11][3:0], sh[10], sh[9]});
      cmp(tol_in_range_o, t >= 20'd10 && t <= 20'd500000);
      cmp(ref_a_cfg_o.lock_tol_eff, t < 20'd10 ? 20'd10 : (t > 20'd500000 ? 20'd500000 : t));
      bus(1'b0, TCR_IDX_STATUS, 8'h00, 4'hf);
      cmp(rd, {29'h0, |{sh[11][3:0], sh[10], sh[9]},
               |{sh[16], sh[15], sh[14], sh[13], sh[12]},
               t >= 20'd10 && t <= 20'd500000});
   endtask
   initial begin
      void'($urandom(32'hec91));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (sh[i]) sh[i] = TCR_RST[i];
      rd_all();
      chk_fields();
      // Default period lies within a picosecond of 51.44 ns.
      cmp(ref_a_cfg_o.period_fs >= 40'd51439000 && ref_a_cfg_o.period_fs <= 40'd51441000, 1);
      // Random fill; reserved bits must read back as zero.
      repeat (4) begin
         for (int i = 0; i < TCR_NREG; i++) begin
            sh[i] = 8'($urandom);
            bus(1'b1, TCR_IDX[i], sh[i], 4'hf);
            sh[i] = sh[i] & TCR_MASK[i];
         end
         chk_fields();
         rd_all();
      end
      // Unmapped, status and unselected writes are acked yet change nothing.
      bus(1'b1, 12'hfff, 8'hff, 4'hf);
      bus(1'b1, TCR_IDX_STATUS, 8'hff, 4'hf);
      bus(1'b1, TCR_IDX[0], ~sh[0], 4'he);
      rd_all();
      // Tolerance on both sides of 10 percent and 2 ppm.
      foreach (tv[k]) begin
         for (int b = 0; b < 3; b++) begin
            sh[17 + b] = 8'(tv[k] >> (8 * b));
            bus(1'b1, TCR_IDX[17 + b], sh[17 + b], 4'hf);
         end
         chk_fields();
      end
      conclude();
   end
   // Watchdog at 20000 cycles, well beyond the under one thousand cycles the tests take.
   initial begin
      #160000;
      miscompares++;
      conclude();
   end
endmodule
`default_nettype wire
